// ### rtl/led_sink_pkg.sv
package led_sink_pkg;

	localparam int NUM_CH       = 16;
	localparam int NUM_GROUPS   = 9;
	localparam int FIFO_DEPTH   = 16;
	localparam int CLK_PERIOD_NS = 100;
	localparam int STAGGER_NS   = 1;
	// Longest time rounds down, but never below one cycle
	localparam int STAGGER_CYC  = (STAGGER_NS / CLK_PERIOD_NS) < 1 ? 1 : (STAGGER_NS / CLK_PERIOD_NS);
	localparam int SYNC_W       = 4;
	localparam int SYNC_SCLK    = 0;
	localparam int SYNC_SDATA   = 1;
	localparam int SYNC_HOLD    = 2;
	localparam int SYNC_BLANK   = 3;
	localparam int MID_CH       = 8;

	typedef struct packed
	{
		logic shift;
		logic sdata;
		logic hold;
	} link_event_t;

	localparam int EVENT_W = $bits(link_event_t);

endpackage

// ### rtl/event_fifo.sv
`timescale 1ns/100ps
module event_fifo
#(
	parameter int WIDTH = 3,
	parameter int DEPTH = 16
)
(
	input  wire logic             mclk_i,
	input  wire logic             reset_n_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	initial
	begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
			$error("event_fifo: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	always_comb
	begin
		push        = in_valid_i && in_ready_o;
		pop         = out_valid_o && out_ready_i;
		next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
		next_count  = (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
	end

	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			wr_ptr      <= '0;
			rd_ptr      <= '0;
			count       <= '0;
			in_ready_o  <= 1'b1;
			out_valid_o <= 1'b0;
		end
		else
		begin
			wr_ptr      <= next_wr_ptr;
			rd_ptr      <= next_rd_ptr;
			count       <= next_count;
			in_ready_o  <= next_count != (AW+1)'(DEPTH);
			out_valid_o <= next_count != '0;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end

	assign out_data_o = mem[rd_ptr];

	a_fifo_no_overrun: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		count == (AW+1)'(DEPTH) |-> !in_ready_o && !push)
		else $error("fifo accepted a word while full");

endmodule

// ### rtl/led_sink_ctrl.sv
`timescale 1ns/100ps
//
// Overview of operation
// - Blanking high forces every sink channel off and enables every pre-charge pull-up.
// - Blanking low lets each channel follow its latched bit and disables all pull-ups.
// - With blanking low a latched one turns its channel on and a zero turns it off.
// - Each shift-clock rising edge moves the whole 16-bit shift register one place toward the MSB.
// - The serial data level is loaded into the LSB at every shift-clock rising edge.
// - The chain data output always shows the register MSB and changes only with a shift.
// - While the hold gate is high the latch is transparent and copies the shift register.
// - While the hold gate is low the latch keeps its contents as shifting continues.
// - Shift register and latch have no reset and no default value.
// - Channels switch staggered in nine groups: 0; 1,15; 2,14; ... 7,9; then 8.
// - The stagger applies to turn-on and turn-off, for blanking changes and latch updates.
module led_sink_ctrl
#(
	parameter int NUM_CH     = led_sink_pkg::NUM_CH,
	parameter int FIFO_DEPTH = led_sink_pkg::FIFO_DEPTH
)
(
	input  wire logic              mclk_i,
	input  wire logic              reset_n_i,
	input  wire logic              shift_clk_i,
	input  wire logic              serial_data_input_i,
	input  wire logic              hold_gate_i,
	input  wire logic              blanking_i,
	output logic      [NUM_CH-1:0] sink_channel_o,
	output logic                   precharge_en_o,
	output logic                   chain_data_output_o,
	output logic                   event_ready_o
);
	localparam int CHAIN = led_sink_pkg::NUM_GROUPS * led_sink_pkg::STAGGER_CYC;

	initial
	begin
		if (NUM_CH != led_sink_pkg::NUM_CH)
			$error("led_sink_ctrl: group map serves 16 channels only");
	end

	function automatic int group_of(input int ch);
		if (ch == 0)
			return 0;
		else if (ch <= led_sink_pkg::MID_CH)
			return ch;
		else
			return NUM_CH - ch;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers and edge detection

	logic [led_sink_pkg::SYNC_W-1:0] sync1;
	logic [led_sink_pkg::SYNC_W-1:0] sync2;
	logic [led_sink_pkg::SYNC_W-1:0] sync3;
	logic                            sclk_rise;
	logic                            hold_edge;
	logic                            blank_s;
	led_sink_pkg::link_event_t       in_ev;

	always_ff @(posedge mclk_i)
	begin
		sync1 <= {blanking_i, hold_gate_i, serial_data_input_i, shift_clk_i};
		sync2 <= sync1;
		sync3 <= sync2;
	end

	always_comb
	begin
		// Only rising shift-clock edges count; falling ones are discarded here, while both hold-gate edges are queued
		sclk_rise   = sync2[led_sink_pkg::SYNC_SCLK] && !sync3[led_sink_pkg::SYNC_SCLK];
		hold_edge   = sync2[led_sink_pkg::SYNC_HOLD] != sync3[led_sink_pkg::SYNC_HOLD];
		blank_s     = sync2[led_sink_pkg::SYNC_BLANK];
		in_ev.shift = sclk_rise;
		in_ev.sdata = sync2[led_sink_pkg::SYNC_SDATA];
		in_ev.hold  = sync2[led_sink_pkg::SYNC_HOLD];
	end

	////////////////////////////////////////////////////////////////////////////
	// Event queue: keeps shift and hold events in order while output stalls

	logic                      push;
	logic                      ev_valid;
	logic                      pop;
	logic                      busy;
	led_sink_pkg::link_event_t ev;

	assign push = sclk_rise || hold_edge;
	assign pop  = ev_valid && !busy;

	event_fifo #(
		.WIDTH (led_sink_pkg::EVENT_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk_i      (mclk_i),
		.reset_n_i   (reset_n_i),
		.in_valid_i  (push),
		.in_ready_o  (event_ready_o),
		.in_data_i   (in_ev),
		.out_valid_o (ev_valid),
		.out_ready_i (!busy),
		.out_data_o  (ev)
	);

	////////////////////////////////////////////////////////////////////////////
	// Shift register, hold gate and latch, deliberately without reset

	logic [NUM_CH-1:0] sreg;
	logic [NUM_CH-1:0] latch;
	logic              hold_q;
	logic [NUM_CH-1:0] next_sreg;
	logic [NUM_CH-1:0] next_latch;
	logic              next_hold;

	always_comb
	begin
		next_sreg = sreg;
		next_hold = hold_q;
		if (pop)
		begin
			next_hold = ev.hold;
			if (ev.shift)
				next_sreg = {sreg[NUM_CH-2:0], ev.sdata};
		end
		next_latch = next_hold ? next_sreg : latch;
	end

	always_ff @(posedge mclk_i)
	begin
		sreg                <= next_sreg;
		latch               <= next_latch;
		hold_q              <= next_hold;
		chain_data_output_o <= next_sreg[NUM_CH-1];
	end

	////////////////////////////////////////////////////////////////////////////
	// Blanking and grouped output stagger

	logic [NUM_CH-1:0] target;
	logic [NUM_CH-1:0] stage [CHAIN];
	logic [NUM_CH-1:0] next_sink;

	always_comb
	begin
		target = blank_s ? '0 : latch;
		// Queue waits until every group has taken the present target
		busy   = 1'b0;
		for (int g = 0; g < CHAIN; g++)
			busy = busy || (stage[g] != target);
		for (int ch = 0; ch < NUM_CH; ch++)
			next_sink[ch] = stage[group_of(ch) * led_sink_pkg::STAGGER_CYC][ch];
	end

	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			for (int g = 0; g < CHAIN; g++)
				stage[g] <= '0;
			sink_channel_o <= '0;
			precharge_en_o <= 1'b1;
		end
		else
		begin
			stage[0] <= target;
			for (int g = 1; g < CHAIN; g++)
				stage[g] <= stage[g-1];
			sink_channel_o <= next_sink;
			precharge_en_o <= blank_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	// Channels 4 and 12 share one group
	localparam int PAIR_LO = led_sink_pkg::MID_CH / 2;
	localparam int PAIR_HI = NUM_CH - PAIR_LO;

	// Cycles of steady blanking, so the all-off check waits out the stagger
	logic [3:0] blank_cnt;

	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
			blank_cnt <= '0;
		else if (!blank_s)
			blank_cnt <= '0;
		else if (blank_cnt != 4'hf)
			blank_cnt <= blank_cnt + 4'h1;
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	a_blank_all_off: assert property (blank_cnt >= 4'hb |-> sink_channel_o == '0)
		else $error("channel on while blanking held");
	a_precharge_follow: assert property (##1 precharge_en_o == $past(blank_s))
		else $error("pre-charge does not follow blanking");
	a_group_first: assert property (##3 sink_channel_o[0] == $past(target[0], 2))
		else $error("group one timing wrong");
	a_group_last: assert property (##12 sink_channel_o[led_sink_pkg::MID_CH] == $past(target[led_sink_pkg::MID_CH], 10))
		else $error("last group timing wrong");
	a_shift_move: assert property (pop && ev.shift |=> sreg == {$past(sreg[NUM_CH-2:0]), $past(ev.sdata)})
		else $error("shift register did not shift");
	a_chain_msb: assert property (!(pop && ev.shift) |=> $stable(chain_data_output_o))
		else $error("chain output changed without a shift");
	a_latch_open: assert property (hold_q |-> latch == sreg)
		else $error("latch not transparent");
	a_latch_hold: assert property (!next_hold |=> $stable(latch))
		else $error("latch changed while holding");
	a_no_fall_push: assert property (sync3[led_sink_pkg::SYNC_SCLK] && !sync2[led_sink_pkg::SYNC_SCLK]
		&& !hold_edge |-> !push)
		else $error("event queued on a falling shift-clock edge");
	a_group_mid: assert property (##7 sink_channel_o[PAIR_LO] == $past(target[PAIR_LO], 6)
		&& sink_channel_o[PAIR_HI] == $past(target[PAIR_HI], 6))
		else $error("paired group timing wrong");
	a_pullup_on: assert property (blank_cnt != 4'h0 |-> precharge_en_o)
		else $error("pre-charge off while blanking held");

	c_shift_seen: cover property (pop && ev.shift);
	c_queue_stall: cover property (ev_valid && busy);
	c_latch_update: cover property (!blank_s && $rose(hold_q));
	c_blank_cycle: cover property ($rose(blank_s) ##[1:50] $fell(blank_s));
	c_fifo_full: cover property (!event_ready_o);

endmodule

// ### test/link_host.sv
`timescale 1ns/100ps
module link_host
(
	input  wire logic mclk_i,
	output logic      shift_clk_o,
	output logic      data_o,
	output logic      hold_o,
	output logic      blank_o
);
	initial
	begin
		shift_clk_o = 1'b0;
		data_o = 1'b0;
		hold_o = 1'b0;
		blank_o = 1'b1;
	end
	////////////////////////////////////////////////////////////
	// MSB first; data settles 3 cycles before each rise
	task automatic send_word(input logic [15:0] w);
		for (int i = 15; i >= 0; i--)
		begin
			@(posedge mclk_i) data_o <= w[i];
			repeat (3) @(posedge mclk_i);
			shift_clk_o <= 1'b1;
			repeat (4) @(posedge mclk_i);
			shift_clk_o <= 1'b0;
		end
		@(posedge mclk_i) data_o <= ~w[0];
	endtask
	task automatic set_pins(input logic hold, input logic blank);
		@(posedge mclk_i);
		hold_o <= hold;
		blank_o <= blank;
	endtask
endmodule

// ### test/tb.sv
`timescale 1ns/100ps
module tb;
	typedef struct {logic [15:0] data; logic blank; logic [15:0] sink; logic pre;} row_t;
	logic        mclk;
	logic        reset_n;
	logic        sclk;
	logic        sdata;
	logic        hold;
	logic        blank;
	logic [15:0] sink;
	logic        pre;
	logic        chain;
	logic        ev_ready;
	int          fail_count;
	int          n_tests;
	row_t        rows [4];
	initial
	begin
		mclk = 1'b0;
		rows = '{'{16'ha5c3, 1'b0, 16'ha5c3, 1'b0}, '{16'h3c5a, 1'b1, 16'h0000, 1'b1},
			'{16'h8001, 1'b0, 16'h8001, 1'b0}, '{16'h7ffe, 1'b0, 16'h7ffe, 1'b0}};
	end
	always #50 mclk = ~mclk;
	link_host host (.mclk_i(mclk), .shift_clk_o(sclk), .data_o(sdata), .hold_o(hold), .blank_o(blank));
	led_sink_ctrl dut (.mclk_i(mclk), .reset_n_i(reset_n), .shift_clk_i(sclk), .serial_data_input_i(sdata),
		.hold_gate_i(hold), .blanking_i(blank), .sink_channel_o(sink), .precharge_en_o(pre),
		.chain_data_output_o(chain), .event_ready_o(ev_ready));
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic settle(input logic [15:0] s, input logic p);
		for (int i = 0; i < 200 && !(sink === s && pre === p); i++)
			@(negedge mclk);
		chk(sink, s);
		chk({15'h0, pre}, {15'h0, p});
		if (fail_count != 0)
			results();
	endtask
	task automatic latch_word(input logic [15:0] w, input logic b);
		host.send_word(w);
		// Latch under the present blanking level; new blanking only once data is valid
		host.set_pins(1'b1, blank);
		repeat (4) @(posedge mclk);
		host.set_pins(1'b0, blank);
		host.set_pins(1'b0, b);
	endtask
	// Groups switch one per cycle: 0; 1,15; ... 7,9; then 8
	task automatic stagger(input logic off);
		logic [16:0] m;
		m = 17'h0;
		for (int i = 0; i < 100 && sink === {16{off}}; i++)
			@(negedge mclk);
		for (int g = 0; g < 9; g++)
		begin
			m = m | (17'h1 << g) | (17'h1 << (16 - g));
			chk(sink, off ? ~m[15:0] : m[15:0]);
			@(negedge mclk);
		end
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		reset_n = 1'b0;
		fail_count = 0;
		n_tests = 0;
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		chk(sink, 16'h0000);
		chk({15'h0, pre}, 16'h0001);
		chk({15'h0, ev_ready}, 16'h0001);
		@(posedge mclk) reset_n <= 1'b1;
		$display("test reset done");
		foreach (rows[i])
		begin
			latch_word(rows[i].data, rows[i].blank);
			settle(rows[i].sink, rows[i].pre);
			chk({15'h0, chain}, {15'h0, rows[i].data[15]});
			$display("test row %0d done", i);
		end
		host.send_word(16'h8000);
		repeat (20) @(posedge mclk);
		@(negedge mclk);
		chk(sink, 16'h7ffe);
		chk({15'h0, chain}, 16'h0001);
		$display("test hold_low done");
		host.set_pins(1'b1, 1'b0);
		host.send_word(16'h0f0f);
		settle(16'h0f0f, 1'b0);
		host.set_pins(1'b0, 1'b0);
		latch_word(16'h0000, 1'b0);
		settle(16'h0000, 1'b0);
		chk({15'h0, ev_ready}, 16'h0001);
		$display("test transparent done");
		host.send_word(16'hffff);
		host.set_pins(1'b1, 1'b0);
		stagger(1'b0);
		host.set_pins(1'b1, 1'b1);
		stagger(1'b1);
		settle(16'h0000, 1'b1);
		$display("test stagger done");
		results();
	end
endmodule
